// File: kwrst_pkg.sv
// Purpose: Shared constants and types of the keyed watchdog reset unit.
// Assumes: System clock of 20 MHz; 8-bit register port with 3-bit address.
// Notes: Offsets and event bit positions are local to this block.
package kwrst_pkg;
  // Clock figures, in hertz.
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned SUB_CLK_HZ = 32_000;
  // The slow subclock is modelled as a tick every SUB_DIV system cycles.
  localparam int unsigned SUB_DIV = SYS_CLK_HZ / SUB_CLK_HZ;
  // Software reset delay in microseconds, and as a count of system cycles.
  localparam int unsigned SRESET_DELAY_US = 100;
  localparam int unsigned SRESET_CYC = SRESET_DELAY_US * (SYS_CLK_HZ / 1_000_000);

  localparam int unsigned CNT_W = 18;
  localparam int unsigned AW = 3;
  localparam int unsigned DW = 8;

  // Register offsets.
  localparam logic [AW-1:0] OFS_CTRL = 3'h0;
  localparam logic [AW-1:0] OFS_FLAGS = 3'h1;
  localparam logic [AW-1:0] OFS_STATUS = 3'h2;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 3'h3;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 3'h4;

  // Control register layout and reset value.
  localparam logic [DW-1:0] CTRL_RESET = 8'h53;
  localparam int unsigned KEY_HI = 7;
  localparam int unsigned KEY_LO = 3;
  localparam int unsigned SEL_HI = 2;
  localparam int unsigned SEL_LO = 0;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0a;

  // Reset cause flag positions.
  localparam int unsigned FLAG_KEY = 0;
  localparam int unsigned FLAG_PIN = 3;
  // Status register positions.
  localparam int unsigned ST_TO = 0;
  localparam int unsigned ST_PDF = 1;
  localparam int unsigned ST_HALT = 2;
  localparam int unsigned ST_EN = 3;
  // Interrupt event positions.
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_KEYRST = 1;
  localparam int unsigned EV_PINRST = 2;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_HALT = 3'b010,
    MODE_KEYDLY = 3'b100
  } kwrst_mode_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } kwrst_bus_s;

  typedef struct packed {
    logic clrWdt;
    logic halt;
    logic wake;
    logic idleKeep;
  } kwrst_cpu_s;

  // Timeout select to power of two of the overflow period.
  function automatic logic [4:0] kwrst_shift(input logic [2:0] sel);
    case (sel)
      3'h0: kwrst_shift = 5'h08;
      3'h1: kwrst_shift = 5'h0a;
      3'h2: kwrst_shift = 5'h0c;
      3'h3: kwrst_shift = 5'h0e;
      3'h4: kwrst_shift = 5'h0f;
      3'h5: kwrst_shift = 5'h10;
      3'h6: kwrst_shift = 5'h11;
      default: kwrst_shift = 5'h12;
    endcase
  endfunction : kwrst_shift
endpackage : kwrst_pkg

// File: kwrst_top.sv
// Purpose: Keyed watchdog with reset cause flags and reset sequencing.
// Assumes: cpuEvt and pinKeyFault come from sys_clk logic; the pin is async.
// Notes: The subclock is a tick derived from sys_clk, not a second domain.
`timescale 1ns/1ps
module kwrst_top #(
  parameter int unsigned SoftResetCycles = kwrst_pkg::SRESET_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire kwrst_pkg::kwrst_bus_s busReq,
  output logic [kwrst_pkg::DW-1:0] rdData_q,
  input wire kwrst_pkg::kwrst_cpu_s cpuEvt,
  input wire logic extResetPinN,
  input wire logic pinResetSel,
  input wire logic pinKeyFault,
  output logic deviceReset_q,
  output logic pcSpReset_q,
  output logic pcClear_q,
  output logic extHold_q,
  output logic portPreset_q,
  output logic toFlag_q,
  output logic pdf_q,
  output logic subOn_q,
  output logic irq_q
);
  import kwrst_pkg::*;

  kwrst_mode_e mode_q;
  logic [DW-1:0] ctrl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [9:0] subDiv_q;
  logic [15:0] dly_q;
  logic flagKey_q;
  logic flagPin_q;
  logic [IRQ_W-1:0] irqStat_q;
  logic [IRQ_W-1:0] irqMask_q;
  logic pinMeta_q;
  logic pinSync_q;
  logic pinLowPrev_q;

  logic [4:0] keyVal;
  logic [2:0] selVal;
  logic enabled;
  logic keyBad;
  logic tick;
  logic [CNT_W-1:0] periodLast;
  logic overflow;
  logic keyFire;
  logic fullReset;
  logic haltTo;
  logic pinLow;
  logic clearCnt;
  logic [IRQ_W-1:0] irqEv;
  logic wrCtrl;
  logic wrFlags;

  // Control fields; the key and select share one byte.
  assign keyVal = ctrl_q[KEY_HI:KEY_LO];
  assign selVal = ctrl_q[SEL_HI:SEL_LO];
  assign enabled = (keyVal == KEY_ENABLE);
  assign keyBad = !enabled && (keyVal != KEY_DISABLE);
  assign wrCtrl = busReq.wr && (busReq.addr == OFS_CTRL);
  assign wrFlags = busReq.wr && (busReq.addr == OFS_FLAGS);

  // Overflow point is one below the selected power of two.
  assign periodLast = CNT_W'(({{CNT_W{1'b0}}, 1'b1} << kwrst_shift(selVal)) - 1'b1);
  assign tick = subOn_q && (subDiv_q == 10'(SUB_DIV - 1));
  assign overflow = tick && enabled && (cnt_q == periodLast);
  assign keyFire = (mode_q == MODE_KEYDLY) && (dly_q == 16'(SoftResetCycles - 1));
  assign pinLow = pinResetSel && !pinSync_q;
  assign fullReset = keyFire || (overflow && mode_q != MODE_HALT);
  assign haltTo = overflow && (mode_q == MODE_HALT);
  // Every count-clearing cause in one term.
  assign clearCnt = keyFire || overflow || cpuEvt.clrWdt || cpuEvt.halt || pinLow;
  assign irqEv = {pinLow && !pinLowPrev_q, keyFire, overflow};

  // Two flops on the reset pin; only the second is read by logic.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
      pinLowPrev_q <= 1'b0;
    end else begin
      pinMeta_q <= extResetPinN;
      pinSync_q <= pinMeta_q;
      pinLowPrev_q <= pinLow;
    end
  end

  // Subclock divider stands in for the RC oscillator; it stops when not needed.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      subDiv_q <= '0;
    end else if (!subOn_q || tick) begin
      subDiv_q <= '0;
    end else begin
      subDiv_q <= subDiv_q + 1'b1;
    end
  end

  // Oscillator request; an enabled watchdog overrides a cleared keep bit.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      subOn_q <= 1'b1;
    end else begin
      subOn_q <= (mode_q != MODE_HALT) || cpuEvt.idleKeep || enabled;
    end
  end

  // Watchdog counter.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (clearCnt) begin
      cnt_q <= '0;
    end else if (tick && enabled) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Operating mode; the pin reset wins over everything else.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_RUN;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (pinLow) begin
            mode_q <= MODE_RUN;
          end else if (keyBad) begin
            mode_q <= MODE_KEYDLY;
          end else if (cpuEvt.halt) begin
            mode_q <= MODE_HALT;
          end
        end
        MODE_HALT: begin
          if (pinLow || haltTo || cpuEvt.wake) begin
            mode_q <= MODE_RUN;
          end else if (keyBad) begin
            mode_q <= MODE_KEYDLY;
          end
        end
        MODE_KEYDLY: begin
          if (pinLow || keyFire) begin
            mode_q <= MODE_RUN;
          end
        end
        default: begin
          mode_q <= MODE_RUN;
        end
      endcase
    end
  end

  // Delay before a key reset; a pin reset during the delay abandons it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dly_q <= '0;
    end else if (mode_q == MODE_KEYDLY && !keyFire) begin
      dly_q <= dly_q + 1'b1;
    end else begin
      dly_q <= '0;
    end
  end

  // Control register; a timeout in halt does not reload it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (fullReset || pinLow) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= busReq.wdata;
    end
  end

  // Reset cause flags; the hardware set beats a software write.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flagKey_q <= 1'b0;
      flagPin_q <= 1'b0;
    end else begin
      if (keyFire) begin
        flagKey_q <= 1'b1;
      end else if (wrFlags) begin
        flagKey_q <= busReq.wdata[FLAG_KEY];
      end
      if (pinKeyFault) begin
        flagPin_q <= 1'b1;
      end else if (wrFlags) begin
        flagPin_q <= busReq.wdata[FLAG_PIN];
      end
    end
  end

  // Timeout and power-down status.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      toFlag_q <= 1'b0;
      pdf_q <= 1'b0;
    end else begin
      if (overflow) begin
        toFlag_q <= 1'b1;
      end else if (cpuEvt.halt || cpuEvt.clrWdt) begin
        toFlag_q <= 1'b0;
      end
      if (cpuEvt.halt) begin
        pdf_q <= 1'b1;
      end else if (cpuEvt.clrWdt) begin
        pdf_q <= 1'b0;
      end
    end
  end

  // Reset outputs towards the core.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      deviceReset_q <= 1'b0;
      pcSpReset_q <= 1'b0;
      pcClear_q <= 1'b1;
      extHold_q <= 1'b0;
      portPreset_q <= 1'b1;
    end else begin
      deviceReset_q <= fullReset;
      pcSpReset_q <= haltTo;
      pcClear_q <= fullReset || haltTo || pinLow;
      extHold_q <= pinLow;
      portPreset_q <= 1'b0;
    end
  end

  // Sticky event bits, cleared by reading; a new event wins over the clear.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_q <= '0;
      irqMask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (busReq.rd && busReq.addr == OFS_IRQ_STAT) begin
        irqStat_q <= irqEv;
      end else begin
        irqStat_q <= irqStat_q | irqEv;
      end
      if (busReq.wr && busReq.addr == OFS_IRQ_MASK) begin
        irqMask_q <= busReq.wdata[IRQ_W-1:0];
      end
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  // Read data stand for exactly one cycle; unmapped addresses read zero.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= '0;
    end else if (busReq.rd) begin
      case (busReq.addr)
        OFS_CTRL: rdData_q <= ctrl_q;
        OFS_FLAGS: begin
          rdData_q <= '0;
          rdData_q[FLAG_KEY] <= flagKey_q;
          rdData_q[FLAG_PIN] <= flagPin_q;
        end
        OFS_STATUS: begin
          rdData_q <= '0;
          rdData_q[ST_TO] <= toFlag_q;
          rdData_q[ST_PDF] <= pdf_q;
          rdData_q[ST_HALT] <= (mode_q == MODE_HALT);
          rdData_q[ST_EN] <= enabled;
        end
        OFS_IRQ_STAT: rdData_q <= DW'(irqStat_q);
        OFS_IRQ_MASK: rdData_q <= DW'(irqMask_q);
        default: rdData_q <= '0;
      endcase
    end else begin
      rdData_q <= '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence haltEnter;
    cpuEvt.halt && mode_q == MODE_RUN && !keyBad && !pinLow && !overflow;
  endsequence
  sequence haltState;
    mode_q == MODE_HALT && pdf_q && !toFlag_q;
  endsequence

  tick_spacing_a: assert property (tick |=> !tick [*8])
    else $error("Subclock ticks too close together.");
  key_reset_a: assert property (keyFire |=> deviceReset_q && flagKey_q)
    else $error("Key reset did not fire or set the flag.");
  ctrl_reload_a: assert property (deviceReset_q |-> ctrl_q == CTRL_RESET)
    else $error("Control not reloaded on reset.");
  halt_timeout_a: assert property (haltTo && !busReq.wr && !pinLow && !cpuEvt.clrWdt |=>
      pcSpReset_q && !deviceReset_q && $stable(ctrl_q) && pdf_q && toFlag_q)
    else $error("Timeout in halt handled wrongly.");
  disabled_quiet_a: assert property (keyVal == KEY_DISABLE |=> !$rose(toFlag_q))
    else $error("Timeout while disabled.");
  count_step_a: assert property (tick && enabled && !clearCnt |=>
      cnt_q == $past(cnt_q) + 1'b1)
    else $error("Counter did not step.");
  count_clear_a: assert property (cpuEvt.clrWdt || pinLow |=> cnt_q == '0)
    else $error("Counter not cleared.");
  normal_timeout_a: assert property (overflow && mode_q == MODE_RUN |=>
      deviceReset_q && toFlag_q)
    else $error("Normal timeout did not reset.");
  flag_sticky_a: assert property (flagKey_q && !wrFlags |=> flagKey_q)
    else $error("Key reset flag lost.");
  halt_entry_a: assert property (haltEnter |=> haltState ##0 cnt_q == '0)
    else $error("Halt entry wrong.");
  sub_keep_a: assert property (mode_q == MODE_HALT && enabled |=> subOn_q)
    else $error("Subclock stopped while enabled.");
  pin_hold_a: assert property (pinLow |=> extHold_q && ctrl_q == CTRL_RESET)
    else $error("Pin reset not held.");
endmodule : kwrst_top

// File: kwrst_top_tb.sv
// Purpose: Self-checking bench for the keyed watchdog reset unit.
// Assumes: An overflow needs over 160000 cycles, so none is run here.
// Notes: Overflow timing is left to the assertions inside the design.
`timescale 1ns/1ps
module kwrst_top_tb;
  import kwrst_pkg::*;
  // A short key delay keeps the invalid key case brief.
  localparam int unsigned SoftCyc = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  kwrst_bus_s busReq = '0;
  kwrst_cpu_s cpuEvt = '0;
  logic extResetPinN = 1'b1;
  logic pinResetSel = 1'b0;
  logic pinKeyFault = 1'b0;
  logic [DW-1:0] rdData_q;
  logic deviceReset_q;
  logic pcSpReset_q;
  logic pcClear_q;
  logic extHold_q;
  logic portPreset_q;
  logic toFlag_q;
  logic pdf_q;
  logic subOn_q;
  logic irq_q;
  int errorCnt = 0;
  int checksDone = 0;
  logic seen;

  // Free running 50 ns clock.
  always #25 sys_clk = ~sys_clk;

  kwrst_top #(.SoftResetCycles(SoftCyc)) u_dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .busReq(busReq),
    .rdData_q(rdData_q),
    .cpuEvt(cpuEvt),
    .extResetPinN(extResetPinN),
    .pinResetSel(pinResetSel),
    .pinKeyFault(pinKeyFault),
    .deviceReset_q(deviceReset_q),
    .pcSpReset_q(pcSpReset_q),
    .pcClear_q(pcClear_q),
    .extHold_q(extHold_q),
    .portPreset_q(portPreset_q),
    .toFlag_q(toFlag_q),
    .pdf_q(pdf_q),
    .subOn_q(subOn_q),
    .irq_q(irq_q)
  );

  // Every task starts just after a rising edge, so strobes never overlap.
  task automatic regWr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq <= '0;
  endtask : regWr

  // Read data are sampled just after the edge that takes the strobe.
  task automatic chkReg(input string name, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    checksDone++;
    if (rdData_q !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", name, exp, rdData_q);
    end
  endtask : chkReg

  task automatic chkBit(input string name, input logic exp, input logic got);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : chkBit

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cycles

  // One cycle pulse of a CPU event; the oscillator keep level stays.
  task automatic cpuPulse(input kwrst_cpu_s v);
    @(posedge sys_clk);
    cpuEvt <= v;
    @(posedge sys_clk);
    cpuEvt <= '{clrWdt: 1'b0, halt: 1'b0, wake: 1'b0, idleKeep: v.idleKeep};
    #1;
  endtask : cpuPulse

  task automatic testDone(input string name);
    $display("test %s finished, mismatches so far %0d", name, errorCnt);
  endtask : testDone

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // The tests need about 150 cycles; the watchdog allows 20000, over a hundred times that.
  initial begin
    #(50 * 20000);
    errorCnt++;
    end_of_test();
  end

  initial begin
    cycles(10);
    chkBit("pcClear in reset", 1'b1, pcClear_q);
    chkBit("portPreset in reset", 1'b1, portPreset_q);
    chkBit("subOn in reset", 1'b1, subOn_q);
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    cycles(2);
    chkBit("portPreset after", 1'b0, portPreset_q);
    chkBit("pcClear after", 1'b0, pcClear_q);
    chkReg("ctrl reset", OFS_CTRL, CTRL_RESET);
    chkReg("flags reset", OFS_FLAGS, 8'h00);
    for (int s = 0; s < 8; s++) begin
      regWr(OFS_CTRL, {KEY_ENABLE, 3'(s)});
      chkReg("ctrl select", OFS_CTRL, {KEY_ENABLE, 3'(s)});
    end
    for (int a = 5; a < 8; a++) begin
      chkReg("unmapped", 3'(a), 8'h00);
    end
    testDone("registers");

    // An invalid key must fire one full reset after the delay.
    regWr(OFS_CTRL, 8'h00);
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      cycles(1);
      seen = (deviceReset_q === 1'b1);
    end
    chkBit("key reset pulse", 1'b1, seen);
    chkReg("flags key", OFS_FLAGS, 8'h01);
    chkReg("ctrl reload", OFS_CTRL, CTRL_RESET);
    regWr(OFS_IRQ_MASK, 8'h07);
    cycles(2);
    chkBit("irq raised", 1'b1, irq_q);
    chkReg("irq stat", OFS_IRQ_STAT, 8'h02);
    cycles(2);
    chkBit("irq cleared", 1'b0, irq_q);
    chkReg("irq stat clear", OFS_IRQ_STAT, 8'h00);
    regWr(OFS_FLAGS, 8'h00);
    chkReg("flags cleared", OFS_FLAGS, 8'h00);
    regWr(OFS_FLAGS, 8'hff);
    chkReg("flags unused", OFS_FLAGS, 8'h09);
    regWr(OFS_FLAGS, 8'h00);
    testDone("invalid key");

    // Halt: with the watchdog disabled the subclock stops in sleep but not in idle; enabled, it keeps running in sleep.
    regWr(OFS_CTRL, {KEY_DISABLE, 3'h0});
    cpuPulse('{clrWdt: 1'b0, halt: 1'b1, wake: 1'b0, idleKeep: 1'b1});
    chkBit("pdf halt", 1'b1, pdf_q);
    chkBit("to halt", 1'b0, toFlag_q);
    // The oscillator request follows the mode one cycle later.
    cycles(1);
    chkBit("subOn idle", 1'b1, subOn_q);
    cpuPulse('{clrWdt: 1'b0, halt: 1'b0, wake: 1'b1, idleKeep: 1'b0});
    cpuPulse('{clrWdt: 1'b0, halt: 1'b1, wake: 1'b0, idleKeep: 1'b0});
    cycles(1);
    chkBit("subOn sleep off", 1'b0, subOn_q);
    chkReg("status off", OFS_STATUS, 8'h06);
    cpuPulse('{clrWdt: 1'b0, halt: 1'b0, wake: 1'b1, idleKeep: 1'b0});
    regWr(OFS_CTRL, CTRL_RESET);
    cpuPulse('{clrWdt: 1'b0, halt: 1'b1, wake: 1'b0, idleKeep: 1'b0});
    cycles(1);
    chkBit("subOn sleep on", 1'b1, subOn_q);
    chkReg("status on", OFS_STATUS, 8'h0e);
    cpuPulse('{clrWdt: 1'b0, halt: 1'b0, wake: 1'b1, idleKeep: 1'b0});
    chkBit("no pc sp reset", 1'b0, pcSpReset_q);
    cpuPulse('{clrWdt: 1'b1, halt: 1'b0, wake: 1'b0, idleKeep: 1'b0});
    chkBit("pdf clear", 1'b0, pdf_q);
    chkReg("status run", OFS_STATUS, 8'h08);
    testDone("halt");

    // A selected pin held low holds reset and wins over a control write.
    @(posedge sys_clk);
    pinResetSel <= 1'b1;
    extResetPinN <= 1'b0;
    cycles(4);
    chkBit("extHold low", 1'b1, extHold_q);
    chkBit("pcClear pin", 1'b1, pcClear_q);
    regWr(OFS_CTRL, {KEY_DISABLE, 3'h1});
    chkReg("ctrl pin held", OFS_CTRL, CTRL_RESET);
    @(posedge sys_clk);
    extResetPinN <= 1'b1;
    cycles(4);
    chkBit("extHold release", 1'b0, extHold_q);
    chkReg("irq pin", OFS_IRQ_STAT, 8'h04);
    @(posedge sys_clk);
    pinKeyFault <= 1'b1;
    @(posedge sys_clk);
    pinKeyFault <= 1'b0;
    chkReg("flags pin key", OFS_FLAGS, 8'h08);
    testDone("pin reset");

    // A second power-on reset in mid-run reloads control and clears the flags.
    regWr(OFS_CTRL, {KEY_DISABLE, 3'h5});
    @(posedge sys_clk);
    resetn <= 1'b0;
    cycles(2);
    chkBit("pcClear mid reset", 1'b1, pcClear_q);
    chkBit("portPreset mid reset", 1'b1, portPreset_q);
    @(posedge sys_clk);
    resetn <= 1'b1;
    cycles(1);
    chkBit("pcClear mid after", 1'b0, pcClear_q);
    chkBit("portPreset mid after", 1'b0, portPreset_q);
    chkReg("ctrl mid reset", OFS_CTRL, CTRL_RESET);
    chkReg("flags mid reset", OFS_FLAGS, 8'h00);
    testDone("second reset");
    end_of_test();
  end
endmodule : kwrst_top_tb
